// ---- hw/pcd_edge_detect.sv ----
/*
  pcd_edge_detect: per-pin rising/falling edge detection for the upper
  second-port pins, rising-only for the third-port pins, with sticky change flags, a
  shared change flag, a wake request and a maskable interrupt.
  Assumes pins synchronous-enough to be double-flopped on mclk, and a
  register master that never asserts read and write strobes together.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
//
// Behaviour
// R01 - second-port bits 7..4 rise enables arm rising detection per pin
// R02 - second-port bits 7..4 fall enables arm falling detection per pin
// R03 - second-port bits 3..0 read zero, writes to them ignored
// R04 - armed rising edge on second-port pin sets its flag
// R05 - armed falling edge sets flag; both enables catch either edge
// R06 - flags readable, writable, hardware set; software clears by writing zero
// R07 - all enables and flags reset to zero on any reset
// R08 - third-port rise enables 7..0 arm rising detection, set third-port flags
// R09 - third-port bits 7..6 and second-port registers only on large variant
// R10 - detection and flags work regardless of change interrupt enable
// R11 - shared change flag is OR of all implemented pin flags
// R12 - edge during flag clearing write leaves that flag set
// R13 - enabled armed edge raises wake; flag already updated by then
// R14 - pins double synchronised; edge is current versus previous sample
`timescale 1ns/1ps
`default_nettype none

module pcd_edge_detect
  import pcd_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [PCD_AW-1:0] addr,
  input wire logic [PCD_DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [PCD_DW-1:0] rdata,
  // port pins
  input wire logic [7:0] second_port_pin,
  input wire logic [7:0] third_port_pin,
  // status and requests
  output logic shared_change_flag,
  output logic change_irq_req,
  output logic wake_req,
  output logic irq
);

  localparam logic [7:0] B_MASK = LARGE_VARIANT ? PCD_B_MASK : PCD_ZERO;
  localparam logic [7:0] C_MASK = LARGE_VARIANT ? PCD_C_MASK_LARGE : PCD_C_MASK_SMALL;

  logic [7:0] pb_s1_r, pb_s2_r, pb_prev_r;
  logic [7:0] pc_s1_r, pc_s2_r, pc_prev_r;
  logic [7:0] b_rise_en_r, b_fall_en_r, b_flags_r, c_rise_en_r, c_flags_r;
  logic [7:0] b_rise_en_nxt, b_fall_en_nxt, b_flags_nxt, c_rise_en_nxt, c_flags_nxt;
  logic [7:0] ctrl_r, ctrl_nxt, stat_r, stat_nxt, irq_en_r, irq_en_nxt;
  logic [7:0] rdata_r, rdata_nxt, rd_mux;
  logic shared_r, shared_nxt, chg_req_r, chg_req_nxt, wake_r, wake_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] b_rise_w, b_fall_w, c_rise_w, b_set, c_set, ev_w, clr_w;
  logic wr_b_rise, wr_b_fall, wr_b_flag, wr_c_rise, wr_c_flag;
  logic wr_ctrl, wr_irq_en, wr_irq_clr, ie_w;

  // R14 two-stage sync
  // first stage feeds only the second; prev holds last synced sample
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pb_s1_r <= PCD_REG_RST;
      pb_s2_r <= PCD_REG_RST;
      pb_prev_r <= PCD_REG_RST;
      pc_s1_r <= PCD_REG_RST;
      pc_s2_r <= PCD_REG_RST;
      pc_prev_r <= PCD_REG_RST;
    end else begin
      pb_s1_r <= second_port_pin;
      pb_s2_r <= pb_s1_r;
      pb_prev_r <= pb_s2_r;
      pc_s1_r <= third_port_pin;
      pc_s2_r <= pc_s1_r;
      pc_prev_r <= pc_s2_r;
    end
  end

  // R14 per-pin edge compare
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      assign b_rise_w[gi] = pb_s2_r[gi] & ~pb_prev_r[gi];
      assign b_fall_w[gi] = ~pb_s2_r[gi] & pb_prev_r[gi];
      assign c_rise_w[gi] = pc_s2_r[gi] & ~pc_prev_r[gi];
    end
  endgenerate

  // R01 R02 R04 R05 armed edge per pin
  // R08 R09 third port rising, variant mask
  assign b_set = B_MASK & ((b_rise_w & b_rise_en_r) | (b_fall_w & b_fall_en_r));
  assign c_set = C_MASK & c_rise_w & c_rise_en_r;

  // write decode
  assign wr_b_rise = wr_stb && (addr == PCD_OFF_B_RISE);
  assign wr_b_fall = wr_stb && (addr == PCD_OFF_B_FALL);
  assign wr_b_flag = wr_stb && (addr == PCD_OFF_B_FLAG);
  assign wr_c_rise = wr_stb && (addr == PCD_OFF_C_RISE);
  assign wr_c_flag = wr_stb && (addr == PCD_OFF_C_FLAG);
  assign wr_ctrl = wr_stb && (addr == PCD_OFF_CTRL);
  assign wr_irq_en = wr_stb && (addr == PCD_OFF_IRQ_EN);
  assign wr_irq_clr = wr_stb && (addr == PCD_OFF_IRQ_CLR);

  // R03 R09 unimplemented bits never stored
  assign b_rise_en_nxt = wr_b_rise ? (wdata & B_MASK) : b_rise_en_r;
  assign b_fall_en_nxt = wr_b_fall ? (wdata & B_MASK) : b_fall_en_r;
  assign c_rise_en_nxt = wr_c_rise ? (wdata & C_MASK) : c_rise_en_r;
  // R06 R12 write stores, hardware set wins
  assign b_flags_nxt = (wr_b_flag ? (wdata & B_MASK) : b_flags_r) | b_set;
  assign c_flags_nxt = (wr_c_flag ? (wdata & C_MASK) : c_flags_r) | c_set;
  assign ctrl_nxt = wr_ctrl ? (wdata & PCD_CTL_MASK) : ctrl_r;
  assign ie_w = ctrl_r[PCD_CTL_IE_BIT];

  // R11 shared flag over all ports
  assign shared_nxt = |{b_flags_nxt, c_flags_nxt};
  // R10 enable gates only the request and the wake, not detection
  assign chg_req_nxt = shared_nxt & ctrl_nxt[PCD_CTL_IE_BIT];
  // R13 wake in the same cycle the flag lands
  assign wake_nxt = ie_w & (|{b_set, c_set});

  // sticky events; a new event beats a clear in the same cycle
  assign ev_w = PCD_IRQ_MASK & {6'b00_0000, |c_set, |b_set};
  assign clr_w = wr_irq_clr ? wdata : PCD_ZERO;
  assign stat_nxt = (stat_r & ~clr_w) | ev_w;
  assign irq_en_nxt = wr_irq_en ? (wdata & PCD_IRQ_MASK) : irq_en_r;
  assign irq_nxt = |(stat_nxt & irq_en_nxt);

  // R03 read mux, unmapped and write-only read zero
  always_comb begin
    rd_mux = PCD_ZERO;
    unique case (addr)
      PCD_OFF_B_RISE: rd_mux = b_rise_en_r;
      PCD_OFF_B_FALL: rd_mux = b_fall_en_r;
      PCD_OFF_B_FLAG: rd_mux = b_flags_r;
      PCD_OFF_C_RISE: rd_mux = c_rise_en_r;
      PCD_OFF_C_FLAG: rd_mux = c_flags_r;
      PCD_OFF_CTRL: rd_mux = ctrl_r | {6'b00_0000, shared_r, 1'b0};
      PCD_OFF_IRQ_STAT: rd_mux = stat_r;
      PCD_OFF_IRQ_EN: rd_mux = irq_en_r;
      default: rd_mux = PCD_ZERO;
    endcase
  end
  assign rdata_nxt = rd_stb ? rd_mux : PCD_ZERO;

  // R07 every register clears on reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      b_rise_en_r <= PCD_REG_RST;
      b_fall_en_r <= PCD_REG_RST;
      b_flags_r <= PCD_REG_RST;
      c_rise_en_r <= PCD_REG_RST;
      c_flags_r <= PCD_REG_RST;
      ctrl_r <= PCD_REG_RST;
      stat_r <= PCD_REG_RST;
      irq_en_r <= PCD_REG_RST;
      rdata_r <= PCD_REG_RST;
      shared_r <= 1'b0;
      chg_req_r <= 1'b0;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      b_rise_en_r <= b_rise_en_nxt;
      b_fall_en_r <= b_fall_en_nxt;
      b_flags_r <= b_flags_nxt;
      c_rise_en_r <= c_rise_en_nxt;
      c_flags_r <= c_flags_nxt;
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      irq_en_r <= irq_en_nxt;
      rdata_r <= rdata_nxt;
      shared_r <= shared_nxt;
      chg_req_r <= chg_req_nxt;
      wake_r <= wake_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rdata = rdata_r;
  assign shared_change_flag = shared_r;
  assign change_irq_req = chg_req_r;
  assign wake_req = wake_r;
  assign irq = irq_r;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    !wr_stb && (b_set == PCD_ZERO) && (c_set == PCD_ZERO);
  endsequence

  sequence s_b_fall_armed;
    (b_fall_w & b_fall_en_r & B_MASK) != PCD_ZERO;
  endsequence

  a_sync_path: assert property ( // R14
    ($past(rst_n) && $past(rst_n, 2)) |-> (pb_s2_r == $past(second_port_pin, 2)))
    else $error("second port sync path is not two stages");

  a_sync_third: assert property ( // R14
    ($past(rst_n) && $past(rst_n, 2)) |-> (pc_s2_r == $past(third_port_pin, 2)))
    else $error("third port sync path is not two stages");

  a_b_set_flag: assert property ( // R04
    (b_set != PCD_ZERO) |=> ((b_flags_r & $past(b_set)) == $past(b_set)))
    else $error("armed second port edge did not set its flag");

  a_b_fall_flag: assert property ( // R05
    s_b_fall_armed |=> ((b_flags_r & $past(b_fall_w & b_fall_en_r)) != PCD_ZERO))
    else $error("armed falling edge did not set a flag");

  a_c_set_flag: assert property ( // R08
    (c_set != PCD_ZERO) ##1 1'b1 |-> ((c_flags_r & $past(c_set)) == $past(c_set)))
    else $error("armed third port edge did not set its flag");

  a_unimpl_zero: assert property ( // R03
    (rd_stb && (addr == PCD_OFF_B_FLAG)) |=> (rdata_r[3:0] == 4'h0))
    else $error("unimplemented second port bits read nonzero");

  a_flags_still: assert property ( // R01
    s_quiet |=> ((b_flags_r == $past(b_flags_r)) && (c_flags_r == $past(c_flags_r))))
    else $error("flag changed without armed edge or write");

  a_flag_write: assert property ( // R06
    (wr_b_flag && (b_set == PCD_ZERO)) |=> (b_flags_r == ($past(wdata) & B_MASK)))
    else $error("flag write not stored");

  a_set_beats_clr: assert property ( // R12
    (wr_b_flag && (wdata == PCD_ZERO) && (b_set != PCD_ZERO)) |=> (b_flags_r != PCD_ZERO))
    else $error("edge lost under clearing write");

  a_variant_bits: assert property ( // R09
    ((c_flags_r & ~C_MASK) == PCD_ZERO) && ((b_rise_en_r & ~B_MASK) == PCD_ZERO))
    else $error("unavailable variant bits became set");

  a_shared_or: assert property ( // R11
    shared_change_flag == (|{b_flags_r, c_flags_r}))
    else $error("shared flag differs from OR of flags");

  a_req_gate: assert property ( // R10
    change_irq_req |-> (ie_w && shared_change_flag))
    else $error("change request without enable or flag");

  a_wake_flag: assert property ( // R13
    (ie_w && ((b_set | c_set) != PCD_ZERO)) |=> (wake_req && shared_change_flag))
    else $error("wake missing or flag not yet set");

  a_reset_zero: assert property ( // R07
    @(posedge mclk) disable iff (1'b0)
    !rst_n |=> ((b_rise_en_r | b_fall_en_r | b_flags_r | c_rise_en_r | c_flags_r) == PCD_ZERO))
    else $error("enables or flags not cleared by reset");

  a_rdata_idle: assert property ( // R03
    !rd_stb |=> (rdata == PCD_ZERO))
    else $error("read data not zero outside a read");

  a_rdata_flag: assert property ( // R06
    (rd_stb && (addr == PCD_OFF_C_FLAG)) |=> (rdata == $past(c_flags_r)))
    else $error("flag read did not return stored flags");

  a_irq_level: assert property ( // R11
    irq == (|(stat_r & irq_en_r)))
    else $error("interrupt differs from enabled status");

  a_wake_cause: assert property ( // R13
    wake_req |-> ($past(ie_w) && ($past(b_set | c_set) != PCD_ZERO)))
    else $error("wake without armed edge and enable");

  a_stat_set_wins: assert property ( // R12
    (wr_irq_clr && (ev_w != PCD_ZERO)) |=> ((stat_r & $past(ev_w)) == $past(ev_w)))
    else $error("status event lost under clear");

  a_unimpl_en: assert property ( // R03
    (rd_stb && ((addr == PCD_OFF_B_RISE) || (addr == PCD_OFF_B_FALL)))
      |=> ((rdata & ~B_MASK) == PCD_ZERO))
    else $error("unimplemented enable bits read nonzero");

  a_detect_no_ie: assert property ( // R10
    (((b_set | c_set) != PCD_ZERO) && !ie_w && !wr_ctrl)
      |=> (shared_change_flag && !change_irq_req))
    else $error("detection stalled or request without enable");

  a_c_flag_write: assert property ( // R06
    (wr_c_flag && (c_set == PCD_ZERO)) |=> (c_flags_r == ($past(wdata) & C_MASK)))
    else $error("third port flag write not stored");

  a_b_rise_write: assert property ( // R01
    wr_b_rise |=> (b_rise_en_r == ($past(wdata) & B_MASK)))
    else $error("second port rise enables not stored");

  a_b_fall_write: assert property ( // R02
    wr_b_fall |=> (b_fall_en_r == ($past(wdata) & B_MASK)))
    else $error("second port fall enables not stored");

  a_c_rise_write: assert property ( // R08
    wr_c_rise |=> (c_rise_en_r == ($past(wdata) & C_MASK)))
    else $error("third port rise enables not stored");

endmodule : pcd_edge_detect

`default_nettype wire

// ---- pkg/pcd_pkg.sv ----
/*
  pcd_pkg: register map, field masks and reset values of the pin change
  edge detector. Assumes an 8-bit register port with a 4-bit word address.
*/
`default_nettype none

package pcd_pkg;
  localparam int PCD_AW = 4;
  localparam int PCD_DW = 8;

  // register word addresses
  localparam logic [3:0] PCD_OFF_B_RISE = 4'h0;
  localparam logic [3:0] PCD_OFF_B_FALL = 4'h1;
  localparam logic [3:0] PCD_OFF_B_FLAG = 4'h2;
  localparam logic [3:0] PCD_OFF_C_RISE = 4'h3;
  localparam logic [3:0] PCD_OFF_C_FLAG = 4'h4;
  localparam logic [3:0] PCD_OFF_CTRL = 4'h5;
  localparam logic [3:0] PCD_OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0] PCD_OFF_IRQ_EN = 4'h7;
  localparam logic [3:0] PCD_OFF_IRQ_CLR = 4'h8;

  // implemented bits per port and variant
  localparam logic [7:0] PCD_B_MASK = 8'hF0;
  localparam logic [7:0] PCD_C_MASK_LARGE = 8'hFF;
  localparam logic [7:0] PCD_C_MASK_SMALL = 8'h3F;
  localparam logic [7:0] PCD_ZERO = 8'h00;
  localparam logic [7:0] PCD_REG_RST = 8'h00;

  // control register fields
  localparam int PCD_CTL_IE_BIT = 0;
  localparam int PCD_CTL_SF_BIT = 1;
  localparam logic [7:0] PCD_CTL_MASK = 8'h01;

  // interrupt status layout
  localparam int PCD_IRQ_B_BIT = 0;
  localparam int PCD_IRQ_C_BIT = 1;
  localparam logic [7:0] PCD_IRQ_MASK = 8'h03;
endpackage : pcd_pkg

`default_nettype wire

// ---- verif/pcd_pin_model.sv ----
/*
  pcd_pin_model: external levels on the second-port and third-port pins.
  assumes the bench changes its commands only just after mclk edges.
*/
`timescale 1ns/1ps
`default_nettype none

module pcd_pin_model (
  // bench commands
  input wire logic [7:0] b_cmd,
  input wire logic [7:0] c_cmd,
  // pin levels
  output logic [7:0] second_port_pin,
  output logic [7:0] third_port_pin
);
  // commands move on edges only, so no pulse is shorter than a clock
  assign second_port_pin = b_cmd;
  assign third_port_pin = c_cmd;
endmodule : pcd_pin_model

`default_nettype wire

// ---- verif/tb_pin_change_edge_detect_b_c.sv ----
/*
  tb_pin_change_edge_detect_b_c: random pin edges checked against flags.
  assumes both variants side by side, fed by pcd_pin_model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_pin_change_edge_detect_b_c;
  import pcd_pkg::*;
  logic mclk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, b_cmd = '0, c_cmd = '0, rdata, rdata_s, bp, cp;
  logic shf, shf_s, cirq, wake, irq;
  logic [7:0] br, bf, cr, bo, co, eb, ec, es, ie, ien, d;
  logic [31:0] seed = 32'hb54c;
  int n_errors = 0, checks_done = 0, i, n_wake = 0, w0;

  always #50 mclk = ~mclk;
  // counting pulses also catches a wake that lasts too long
  always @(posedge mclk) if (wake === 1'b1) n_wake <= n_wake + 1;

  pcd_edge_detect #(.LARGE_VARIANT(1'b1)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .second_port_pin(bp), .third_port_pin(cp), .shared_change_flag(shf),
    .change_irq_req(cirq), .wake_req(wake), .irq(irq));
  pcd_pin_model pins (.b_cmd(b_cmd), .c_cmd(c_cmd), .second_port_pin(bp),
    .third_port_pin(cp));
  pcd_edge_detect #(.LARGE_VARIANT(1'b0)) dut_small (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata_s),
    .second_port_pin(bp), .third_port_pin(cp), .shared_change_flag(shf_s),
    .change_irq_req(), .wake_req(), .irq());

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] edges(input logic [7:0] r, f, o, n);
    return (r & ~o & n) | (f & o & ~n);
  endfunction : edges

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] exp_s);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
    chk(rdata_s, exp_s);
  endtask : rd
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // nothing here waits open-ended; this only guards a stuck run
  initial begin
    #3000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) rd(i[3:0], 8'h00, 8'h00);
    wr(PCD_OFF_B_RISE, 8'hFF);
    rd(PCD_OFF_B_RISE, 8'hF0, 8'h00);
    wr(PCD_OFF_B_FALL, 8'h0F);
    rd(PCD_OFF_B_FALL, 8'h00, 8'h00);
    wr(PCD_OFF_C_RISE, 8'hFF);
    rd(PCD_OFF_C_RISE, 8'hFF, PCD_C_MASK_SMALL);
    for (i = 0; i < 30; i++) begin
      br = rnd() & PCD_B_MASK;
      bf = rnd() & PCD_B_MASK;
      cr = rnd();
      ie = rnd() & PCD_CTL_MASK;
      ien = rnd() & PCD_IRQ_MASK;
      // first two rounds: all edges armed, every pin toggles
      if (i < 2) begin
        br = 8'hF0;
        bf = 8'hF0;
        cr = 8'hFF;
      end
      wr(PCD_OFF_B_RISE, br);
      wr(PCD_OFF_B_FALL, bf);
      wr(PCD_OFF_C_RISE, cr);
      wr(PCD_OFF_CTRL, ie);
      wr(PCD_OFF_IRQ_EN, ien);
      wr(PCD_OFF_B_FLAG, 8'h00);
      wr(PCD_OFF_C_FLAG, 8'h00);
      wr(PCD_OFF_IRQ_CLR, 8'h03);
      repeat (2) @(posedge mclk);
      w0 = n_wake;
      bo = b_cmd;
      co = c_cmd;
      d = (i < 2) ? ~bo : rnd();
      b_cmd <= d;
      eb = edges(br, bf, bo, d) & PCD_B_MASK;
      d = (i < 2) ? ~co : rnd();
      c_cmd <= d;
      ec = edges(cr, 8'h00, co, d);
      es = ec & PCD_C_MASK_SMALL;
      repeat (4) @(posedge mclk);
      #1;
      chk({7'h00, shf}, {7'h00, |{eb, ec}});
      chk({7'h00, shf_s}, {7'h00, |es});
      chk({7'h00, cirq}, {7'h00, |{eb, ec} & ie[0]});
      chk(8'(n_wake - w0), {7'h00, |{eb, ec} & ie[0]});
      chk({7'h00, irq}, {7'h00, |({|ec, |eb} & ien[1:0])});
      rd(PCD_OFF_B_FLAG, eb, 8'h00);
      rd(PCD_OFF_C_FLAG, ec, es);
      rd(PCD_OFF_IRQ_STAT, {6'h00, |ec, |eb}, {6'h00, |es, 1'b0});
      rd(PCD_OFF_CTRL, {6'h00, |{eb, ec}, ie[0]}, {6'h00, |es, ie[0]});
      rd(PCD_OFF_IRQ_EN, ien, ien);
    end
    wr(PCD_OFF_B_FLAG, 8'hFF);
    rd(PCD_OFF_B_FLAG, 8'hF0, 8'h00);
    wr(PCD_OFF_B_RISE, 8'h10);
    wr(PCD_OFF_B_FALL, 8'h00);
    b_cmd <= 8'h00;
    repeat (4) @(posedge mclk);
    wr(PCD_OFF_B_FLAG, 8'h00);
    rd(PCD_OFF_B_FLAG, 8'h00, 8'h00);
    // clearing write lands on the very edge the flag is set
    @(posedge mclk);
    b_cmd <= 8'h10;
    @(posedge mclk);
    wr(PCD_OFF_B_FLAG, 8'h00);
    rd(PCD_OFF_B_FLAG, 8'h10, 8'h00);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(PCD_OFF_B_FLAG, 8'h00, 8'h00);
    rd(PCD_OFF_B_RISE, 8'h00, 8'h00);
    rd(PCD_OFF_C_RISE, 8'h00, 8'h00);
    report_and_stop();
  end
endmodule : tb_pin_change_edge_detect_b_c

`default_nettype wire
